// File: gpt_event_source.sv
// Event source for the counter pins and a free-running slow oscillator
`default_nettype none
module gpt_event_source (
   input wire logic clk,
   output logic pin,
   output logic osc
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin = 1'b1;
   initial osc = 1'b0;
   // Oscillator runs free, unrelated in phase to the system clock
   always #41 osc = ~osc;
   // Each level stands hold cycles; hold of two is the quarter-rate case
   task automatic pulses(input int n, input int hold);
      repeat (n) begin
         @(posedge clk);
         pin <= 1'b0;
         repeat (hold) @(posedge clk);
         pin <= 1'b1;
         repeat (hold - 1) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// File: gpt_timer_regs.vh
// Register offsets, field positions and timing constants of the timer set
`ifndef GPT_TIMER_REGS_VH
`define GPT_TIMER_REGS_VH
`define GPT_CLK_MHZ 100
`define GPT_ADR_CLKCTL 8'h00
`define GPT_ADR_T01MODE 8'h04
`define GPT_ADR_T01CTL 8'h08
`define GPT_ADR_T0CNT 8'h0C
`define GPT_ADR_T1CNT 8'h10
`define GPT_ADR_T2CTL 8'h14
`define GPT_ADR_T2CNT 8'h18
`define GPT_ADR_T2RLD 8'h1C
`define GPT_ADR_T3CTL 8'h20
`define GPT_ADR_T3CNT 8'h24
`define GPT_ADR_T3RLD 8'h28
`define GPT_ADR_IRQSTAT 8'h2C
`define GPT_ADR_IRQMASK 8'h30
`define GPT_ADR_T2CAP 8'h34
`define GPT_ADR_T3CAP 8'h38
`define GPT_CLKCTL_RST 8'h00
`define GPT_CK_SCA_LO 0
`define GPT_CK_T0SYS 2
`define GPT_CK_T1SYS 3
`define GPT_CK_T2SYSL 4
`define GPT_CK_T2SYSH 5
`define GPT_CK_T3SYSL 6
`define GPT_CK_T3SYSH 7
`define GPT_TC_RUN0 0
`define GPT_TC_RUN1 1
`define GPT_TA_RUN 0
`define GPT_TA_SPLIT 1
`define GPT_TA_XCLK_LO 2
`define GPT_TA_CAPEN 4
`define GPT_TA_RUNH 5
`define GPT_IRQ_WIDTH 8
`define GPT_DIV12 12
`define GPT_DIV4 4
`define GPT_DIV48 48
`define GPT_DIV8 8
`endif

// File: gpt_timer_set.v
// Four counter/timers with classic Wishbone register access
`include "gpt_timer_regs.vh"
`default_nettype none
module gpt_timer_set (
   input wire MCLK,
   input wire NRST,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   input wire TIMER_ZERO_COUNT_INPUT,
   input wire TIMER_ONE_COUNT_INPUT,
   input wire EXTERNAL_GATE_INPUT_ZERO,
   input wire EXTERNAL_GATE_INPUT_ONE,
   input wire COMPARATOR_ZERO_OUT,
   input wire COMPARATOR_ONE_OUT,
   input wire LF_OSC_CLK,
   input wire EXT_OSC_CLK,
   output wire IRQ
);
// ==========================================================
// Input synchronisers: three stages, change taken when 2 and 3 agree
// ==========================================================
localparam NIN = 8;
wire [NIN-1:0] pin_raw = {EXT_OSC_CLK, LF_OSC_CLK, COMPARATOR_ONE_OUT,
   COMPARATOR_ZERO_OUT, EXTERNAL_GATE_INPUT_ONE, EXTERNAL_GATE_INPUT_ZERO,
   TIMER_ONE_COUNT_INPUT, TIMER_ZERO_COUNT_INPUT};
reg [NIN-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
always @(posedge MCLK or negedge NRST) begin
   if (!NRST) begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
      s3_reg <= 8'h00;
      lvl_reg <= 8'h00;
   end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
   end
end
// Falling edge only after a settled high then a settled low
wire [NIN-1:0] lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
wire [NIN-1:0] fall = lvl_reg & ~lvl_next;
wire [NIN-1:0] rise = ~lvl_reg & lvl_next;
// ==========================================================
// Registers
// ==========================================================
reg [7:0] clkctl_reg;
reg [7:0] t01mode_reg;
reg [1:0] t01ctl_reg;
reg [15:0] t0_reg, t1_reg, t2_reg, t3_reg, t2rld_reg, t3rld_reg;
reg [15:0] t2cap_reg, t3cap_reg;
reg [5:0] t2ctl_reg, t3ctl_reg;
reg [7:0] stat_reg, mask_reg;
assign IRQ = |(stat_reg & mask_reg);
wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
wire wr_lo = wb_req & WB_WE_I & WB_SEL_I[0];
wire wr_hi = wb_req & WB_WE_I & WB_SEL_I[1];
function [15:0] merge16;
   input [15:0] old;
   input [15:0] d;
   input lo, hi;
   begin
      merge16 = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
   end
endfunction
// ==========================================================
// Prescaler for timers zero/one and the divide-by-12 for two/three
// ==========================================================
reg [5:0] pre_cnt_reg;
reg [3:0] div12_reg;
reg [2:0] ext8_reg, lf8_reg;
wire [1:0] sca = clkctl_reg[`GPT_CK_SCA_LO+1:`GPT_CK_SCA_LO];
wire [5:0] pre_top = (sca == 2'b00) ? 6'd11 : (sca == 2'b01) ? 6'd3 : 6'd47;
wire ext_tick = rise[7] & (ext8_reg == 3'd7);
wire lf_tick = rise[6] & (lf8_reg == 3'd7);
wire pre_tick = (sca == 2'b11) ? ext_tick : (pre_cnt_reg >= pre_top);
wire div12_tick = (div12_reg == 4'd11);
always @(posedge MCLK or negedge NRST) begin
   if (!NRST) begin
      pre_cnt_reg <= 6'd0;
      div12_reg <= 4'd0;
      ext8_reg <= 3'd0;
      lf8_reg <= 3'd0;
   end else begin
      pre_cnt_reg <= (pre_cnt_reg >= pre_top) ? 6'd0 : pre_cnt_reg + 6'd1;
      div12_reg <= div12_tick ? 4'd0 : div12_reg + 4'd1;
      if (rise[7]) ext8_reg <= ext8_reg + 3'd1;
      if (rise[6]) lf8_reg <= lf8_reg + 3'd1;
   end
end
// ==========================================================
// Timers zero and one
// ==========================================================
// Mode byte per timer nibble: [1:0] mode, [2] counter, [3] gating
wire [1:0] m0 = t01mode_reg[1:0];
wire [1:0] m1 = t01mode_reg[5:4];
function tick01;
   input counter, fall_in, sys_sel, pre;
   begin
      tick01 = counter ? fall_in : (sys_sel ? 1'b1 : pre);
   end
endfunction
wire tk0 = tick01(t01mode_reg[2], fall[0],
   clkctl_reg[`GPT_CK_T0SYS], pre_tick);
wire tk1 = tick01(t01mode_reg[6], fall[1],
   clkctl_reg[`GPT_CK_T1SYS], pre_tick);
wire run0 = t01ctl_reg[`GPT_TC_RUN0] & (~t01mode_reg[3] | lvl_reg[2]);
wire run1 = t01ctl_reg[`GPT_TC_RUN1] & (~t01mode_reg[7] | lvl_reg[3]);
// Timer zero split mode borrows timer one's run bit for its high byte
wire split0 = (m0 == 2'b11);
wire en0 = run0 & tk0;
wire en0h = split0 ? (t01ctl_reg[`GPT_TC_RUN1] & pre_tick) : 1'b0;
wire en1 = run1 & tk1 & (m1 != 2'b11); // mode 3 halts timer one
function [16:0] step01;
   input [1:0] mode;
   input [15:0] v;
   reg [8:0] lo;
   reg [13:0] c13;
   reg [16:0] c16;
   begin
      lo = {1'b0, v[7:0]} + 9'd1;
      c13 = {1'b0, v[15:8], v[4:0]} + 14'd1;
      c16 = {1'b0, v} + 17'd1;
      case (mode)
         2'b00: step01 = {c13[13], c13[12:5], 3'b000, c13[4:0]};
         2'b01: step01 = c16;
         2'b10: step01 = {lo[8], v[15:8], lo[8] ? v[15:8] : lo[7:0]};
         default: step01 = {lo[8], v[15:8], lo[7:0]};
      endcase
   end
endfunction
wire [16:0] n0 = step01(m0, t0_reg);
wire [16:0] n1 = step01(m1, t1_reg);
wire [8:0] n0h = {1'b0, t0_reg[15:8]} + 9'd1;
// ==========================================================
// Timers two and three: auto-reload, split, capture
// ==========================================================
// Control: [0] run, [1] split, [3:2] ext clock select, [4] capture, [5] run hi
function ext_tick23;
   input [1:0] xsel;
   input d12, osc, cmp;
   begin
      case (xsel)
         2'b00: ext_tick23 = d12;
         2'b01: ext_tick23 = osc;
         default: ext_tick23 = cmp;
      endcase
   end
endfunction
wire x2 = ext_tick23(t2ctl_reg[3:2], div12_tick, lf_tick, rise[4]);
wire x3 = ext_tick23(t3ctl_reg[3:2], div12_tick, ext_tick, rise[5]);
// In capture mode the timer counts the system clock, the reference latches it
wire cap2 = t2ctl_reg[`GPT_TA_CAPEN];
wire cap3 = t3ctl_reg[`GPT_TA_CAPEN];
wire tk2l = cap2 ? 1'b1 : (clkctl_reg[`GPT_CK_T2SYSL] | x2);
wire tk2h = clkctl_reg[`GPT_CK_T2SYSH] | div12_tick;
wire tk3l = cap3 ? 1'b1 : (clkctl_reg[`GPT_CK_T3SYSL] | x3);
wire tk3h = clkctl_reg[`GPT_CK_T3SYSH] | div12_tick;
function [17:0] step23;
   input split, el, eh;
   input [15:0] v, r;
   reg [16:0] f;
   reg [8:0] l, h;
   begin
      f = {1'b0, v} + 17'd1;
      l = {1'b0, v[7:0]} + 9'd1;
      h = {1'b0, v[15:8]} + 9'd1;
      if (!split) begin
         step23 = {1'b0, el & f[16], el ? (f[16] ? r : f[15:0]) : v};
      end else begin
         step23 = {eh & h[8], el & l[8],
            eh ? (h[8] ? r[15:8] : h[7:0]) : v[15:8],
            el ? (l[8] ? r[7:0] : l[7:0]) : v[7:0]};
      end
   end
endfunction
wire [17:0] n2 = step23(t2ctl_reg[`GPT_TA_SPLIT],
   t2ctl_reg[`GPT_TA_RUN] & tk2l,
   t2ctl_reg[`GPT_TA_RUNH] & tk2h, t2_reg, t2rld_reg);
wire [17:0] n3 = step23(t3ctl_reg[`GPT_TA_SPLIT],
   t3ctl_reg[`GPT_TA_RUN] & tk3l,
   t3ctl_reg[`GPT_TA_RUNH] & tk3h, t3_reg, t3rld_reg);
wire cap2_ev = cap2 & t2ctl_reg[`GPT_TA_RUN] & x2;
wire cap3_ev = cap3 & t3ctl_reg[`GPT_TA_RUN] & x3;
// Status: 0 t0 ovf, 1 t1 ovf, 2 t0 high ovf, 3/4 t2 lo/hi, 5/6 t3, 7 cap
wire [7:0] ev = {cap2_ev | cap3_ev, n3[17:16], n2[17:16],
   en0h & n0h[8], en1 & n1[16], en0 & n0[16]};
// ==========================================================
// Register writes and counting; a bus write wins over a count
// ==========================================================
always @(posedge MCLK or negedge NRST) begin
   if (!NRST) begin
      clkctl_reg <= `GPT_CLKCTL_RST;
      t01mode_reg <= 8'h00;
      t01ctl_reg <= 2'b00;
      t0_reg <= 16'h0000;
      t1_reg <= 16'h0000;
      t2_reg <= 16'h0000;
      t3_reg <= 16'h0000;
      t2rld_reg <= 16'h0000;
      t3rld_reg <= 16'h0000;
      t2cap_reg <= 16'h0000;
      t3cap_reg <= 16'h0000;
      t2ctl_reg <= 6'h00;
      t3ctl_reg <= 6'h00;
      stat_reg <= 8'h00;
      mask_reg <= 8'h00;
   end else begin
      // Run bit writes touch only control; counts keep their value
      if (wb_wr && WB_ADR_I == `GPT_ADR_CLKCTL) clkctl_reg <= WB_DAT_I[7:0];
      if (wb_wr && WB_ADR_I == `GPT_ADR_T01MODE) t01mode_reg <= WB_DAT_I[7:0];
      if (wb_wr && WB_ADR_I == `GPT_ADR_T01CTL) t01ctl_reg <= WB_DAT_I[1:0];
      if (wb_wr && WB_ADR_I == `GPT_ADR_T2CTL) t2ctl_reg <= WB_DAT_I[5:0];
      if (wb_wr && WB_ADR_I == `GPT_ADR_T3CTL) t3ctl_reg <= WB_DAT_I[5:0];
      if (wb_wr && WB_ADR_I == `GPT_ADR_IRQMASK) mask_reg <= WB_DAT_I[7:0];
      if (wb_req && WB_WE_I && WB_ADR_I == `GPT_ADR_T2RLD)
         t2rld_reg <= merge16(t2rld_reg, WB_DAT_I[15:0], wr_lo, wr_hi);
      if (wb_req && WB_WE_I && WB_ADR_I == `GPT_ADR_T3RLD)
         t3rld_reg <= merge16(t3rld_reg, WB_DAT_I[15:0], wr_lo, wr_hi);
      if (wb_req && WB_WE_I && WB_ADR_I == `GPT_ADR_T0CNT)
         t0_reg <= merge16(t0_reg, WB_DAT_I[15:0], wr_lo, wr_hi);
      else begin
         if (en0) t0_reg[7:0] <= n0[7:0];
         if (split0) begin
            if (en0h) t0_reg[15:8] <= n0h[7:0];
         end else if (en0) t0_reg[15:8] <= n0[15:8];
      end
      if (wb_req && WB_WE_I && WB_ADR_I == `GPT_ADR_T1CNT)
         t1_reg <= merge16(t1_reg, WB_DAT_I[15:0], wr_lo, wr_hi);
      else if (en1) t1_reg <= n1[15:0];
      if (wb_req && WB_WE_I && WB_ADR_I == `GPT_ADR_T2CNT)
         t2_reg <= merge16(t2_reg, WB_DAT_I[15:0], wr_lo, wr_hi);
      else t2_reg <= n2[15:0];
      if (wb_req && WB_WE_I && WB_ADR_I == `GPT_ADR_T3CNT)
         t3_reg <= merge16(t3_reg, WB_DAT_I[15:0], wr_lo, wr_hi);
      else t3_reg <= n3[15:0];
      if (cap2_ev) t2cap_reg <= t2_reg;
      if (cap3_ev) t3cap_reg <= t3_reg;
      // Set wins over a write-one clear in the same cycle
      if (wb_wr && WB_ADR_I == `GPT_ADR_IRQSTAT)
         stat_reg <= (stat_reg & ~WB_DAT_I[7:0]) | ev;
      else
         stat_reg <= stat_reg | ev;
   end
end
// ==========================================================
// Wishbone read path and acknowledge: one wait state, ack for one cycle
// ==========================================================
reg [31:0] rd_next;
always @* begin
   rd_next = 32'h00000000;
   if (WB_ADR_I == `GPT_ADR_CLKCTL) rd_next[7:0] = clkctl_reg;
   else if (WB_ADR_I == `GPT_ADR_T01MODE) rd_next[7:0] = t01mode_reg;
   else if (WB_ADR_I == `GPT_ADR_T01CTL) rd_next[1:0] = t01ctl_reg;
   else if (WB_ADR_I == `GPT_ADR_T0CNT) rd_next[15:0] = t0_reg;
   else if (WB_ADR_I == `GPT_ADR_T1CNT) rd_next[15:0] = t1_reg;
   else if (WB_ADR_I == `GPT_ADR_T2CTL) rd_next[5:0] = t2ctl_reg;
   else if (WB_ADR_I == `GPT_ADR_T2CNT) rd_next[15:0] = t2_reg;
   else if (WB_ADR_I == `GPT_ADR_T2RLD) rd_next[15:0] = t2rld_reg;
   else if (WB_ADR_I == `GPT_ADR_T3CTL) rd_next[5:0] = t3ctl_reg;
   else if (WB_ADR_I == `GPT_ADR_T3CNT) rd_next[15:0] = t3_reg;
   else if (WB_ADR_I == `GPT_ADR_T3RLD) rd_next[15:0] = t3rld_reg;
   else if (WB_ADR_I == `GPT_ADR_IRQSTAT) rd_next[7:0] = stat_reg;
   else if (WB_ADR_I == `GPT_ADR_IRQMASK) rd_next[7:0] = mask_reg;
   else if (WB_ADR_I == `GPT_ADR_T2CAP) rd_next[15:0] = t2cap_reg;
   else if (WB_ADR_I == `GPT_ADR_T3CAP) rd_next[15:0] = t3cap_reg;
   else rd_next = 32'h00000000;
end
always @(posedge MCLK or negedge NRST) begin
   if (!NRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
   end else begin
      WB_ACK_O <= wb_req;
      if (wb_req) WB_DAT_O <= rd_next;
   end
end
endmodule
`default_nettype wire

// File: gpt_timer_set_assertions.sv
// Port-level checker for the timer set, bound to its top module
`include "gpt_timer_regs.vh"
`default_nettype none
module gpt_timer_set_checker (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic TIMER_ZERO_COUNT_INPUT,
   input wire logic TIMER_ONE_COUNT_INPUT,
   input wire logic EXTERNAL_GATE_INPUT_ZERO,
   input wire logic EXTERNAL_GATE_INPUT_ONE,
   input wire logic COMPARATOR_ZERO_OUT,
   input wire logic COMPARATOR_ONE_OUT,
   input wire logic LF_OSC_CLK,
   input wire logic EXT_OSC_CLK,
   input wire logic IRQ
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!NRST);
   // ==========================================================
   // Shadows of writable control bytes
   logic [7:0] clk_sh_reg;
   logic [7:0] mode_sh_reg;
   logic [7:0] mask_sh_reg;
   wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   wire wr_take = take && WB_WE_I && WB_SEL_I[0];
   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         clk_sh_reg <= 8'h00;
         mode_sh_reg <= 8'h00;
         mask_sh_reg <= 8'h00;
      end else begin
         if (wr_take && WB_ADR_I == `GPT_ADR_CLKCTL)
            clk_sh_reg <= WB_DAT_I[7:0];
         if (wr_take && WB_ADR_I == `GPT_ADR_T01MODE)
            mode_sh_reg <= WB_DAT_I[7:0];
         if (wr_take && WB_ADR_I == `GPT_ADR_IRQMASK)
            mask_sh_reg <= WB_DAT_I[7:0];
      end
   end
   // ==========================================================
   // Assertions
   sequence rd_at(logic [7:0] a);
      take && !WB_WE_I && WB_ADR_I == a;
   endsequence
   ack_answer_a: assert property (take |=> WB_ACK_O)
      else $error("ack missing after request");
   ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property ($rose(WB_ACK_O) |->
      $past(WB_CYC_I && WB_STB_I)) else $error("ack without request");
   dat_hold_a: assert property (!take |=> $stable(WB_DAT_O))
      else $error("read data moved while idle");
   unmapped_zero_a: assert property (rd_at(8'h3C) |=> WB_DAT_O == 0)
      else $error("unmapped read not zero");
   clk_readback_a: assert property (rd_at(`GPT_ADR_CLKCTL) |=>
      WB_DAT_O[7:0] == clk_sh_reg) else $error("clock select readback");
   mode_readback_a: assert property (rd_at(`GPT_ADR_T01MODE) |=>
      WB_DAT_O[7:0] == mode_sh_reg) else $error("mode readback");
   irq_masked_a: assert property (mask_sh_reg == 8'h00 |-> !IRQ)
      else $error("interrupt while all masked");
endmodule
bind gpt_timer_set gpt_timer_set_checker chk_i (.MCLK(MCLK), .NRST(NRST),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .TIMER_ZERO_COUNT_INPUT(TIMER_ZERO_COUNT_INPUT),
   .TIMER_ONE_COUNT_INPUT(TIMER_ONE_COUNT_INPUT),
   .EXTERNAL_GATE_INPUT_ZERO(EXTERNAL_GATE_INPUT_ZERO),
   .EXTERNAL_GATE_INPUT_ONE(EXTERNAL_GATE_INPUT_ONE),
   .COMPARATOR_ZERO_OUT(COMPARATOR_ZERO_OUT),
   .COMPARATOR_ONE_OUT(COMPARATOR_ONE_OUT), .LF_OSC_CLK(LF_OSC_CLK),
   .EXT_OSC_CLK(EXT_OSC_CLK), .IRQ(IRQ));
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the timer set
`include "gpt_timer_regs.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, timer_zero_gating_enable = 1'b0, cmp = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic ack, irq, pin, osc;
   int error_cnt = 0, num_checks = 0, cycles = 0, seed = 32'hd13b206c;
   gpt_timer_set uut (.MCLK(clk), .NRST(nrst), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .TIMER_ZERO_COUNT_INPUT(pin), .TIMER_ONE_COUNT_INPUT(pin),
      .EXTERNAL_GATE_INPUT_ZERO(timer_zero_gating_enable), .EXTERNAL_GATE_INPUT_ONE(timer_zero_gating_enable),
      .COMPARATOR_ZERO_OUT(cmp), .COMPARATOR_ONE_OUT(cmp),
      .LF_OSC_CLK(osc), .EXT_OSC_CLK(osc), .IRQ(irq));
   gpt_event_source src (.clk(clk), .pin(pin), .osc(osc));
   always #5 clk = ~clk;
   // ==========================================================
   // Tasks
   task automatic test_done();
      if (error_cnt == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic bus(input logic w, input logic [7:0] a, input int d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input int d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 0);
   endtask
   task automatic chk(input logic [31:0] got, input int lo, input int hi);
      num_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h..%h", $time, got,
            lo, hi);
      end
   endtask
   // Ticks of the prescaled clock over a 480-cycle run
   function automatic int ticks(input int code);
      case (code)
         0: return 480 / `GPT_DIV12;
         1: return 480 / `GPT_DIV4;
         2: return 480 / `GPT_DIV48;
         default: return 4800 / (82 * `GPT_DIV8);
      endcase
   endfunction
   // ==========================================================
   // Main sequence
   initial begin
      int v, k, h, c;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rd(`GPT_ADR_CLKCTL);
      chk(q, 0, 0);
      rd(8'h3C);
      chk(q, 0, 0);
      wr(`GPT_ADR_CLKCTL, 32'h04);
      wr(`GPT_ADR_T01MODE, 32'h01);
      v = $random(seed) & 32'h7FFF;
      wr(`GPT_ADR_T0CNT, v);
      wr(`GPT_ADR_T01CTL, 32'h01);
      repeat (30) @(posedge clk);
      wr(`GPT_ADR_T01CTL, 32'h00);
      rd(`GPT_ADR_T0CNT);
      chk(q, v + 31, v + 35);
      for (c = 0; c < 4; c++) begin
         wr(`GPT_ADR_CLKCTL, c);
         wr(`GPT_ADR_T0CNT, 0);
         wr(`GPT_ADR_T01CTL, 32'h01);
         repeat (477) @(posedge clk);
         wr(`GPT_ADR_T01CTL, 32'h00);
         rd(`GPT_ADR_T0CNT);
         chk(q, ticks(c) - 1, ticks(c) + 1);
      end
      // 13-bit counter two events short of wrap
      wr(`GPT_ADR_IRQMASK, 32'h01);
      wr(`GPT_ADR_T01MODE, 32'h04);
      wr(`GPT_ADR_T0CNT, 32'hFF1E);
      wr(`GPT_ADR_T01CTL, 32'h01);
      src.pulses(2, 2);
      repeat (6) @(posedge clk);
      chk(irq, 1, 1);
      rd(`GPT_ADR_T0CNT);
      chk(q, 0, 0);
      k = 1 + ($random(seed) & 7);
      h = 2 + ($random(seed) & 1);
      src.pulses(k, h);
      repeat (6) @(posedge clk);
      rd(`GPT_ADR_T0CNT);
      chk(q, k, k);
      wr(`GPT_ADR_IRQSTAT, 32'h01);
      chk(irq, 0, 0);
      wr(`GPT_ADR_T01MODE, 32'h0C);
      rd(`GPT_ADR_T01MODE);
      chk(q, 32'h0C, 32'h0C);
      wr(`GPT_ADR_T0CNT, 0);
      src.pulses(3, 2);
      repeat (6) @(posedge clk);
      rd(`GPT_ADR_T0CNT);
      chk(q, 0, 0);
      timer_zero_gating_enable <= 1'b1;
      src.pulses(2, 2);
      repeat (6) @(posedge clk);
      rd(`GPT_ADR_T0CNT);
      chk(q, 2, 2);
      // Auto-reload timer crossing its overflow once
      wr(`GPT_ADR_CLKCTL, 32'h10);
      wr(`GPT_ADR_T2RLD, 32'hFFF0);
      wr(`GPT_ADR_T2CNT, 32'hFFF8);
      wr(`GPT_ADR_T2CTL, 32'h01);
      repeat (11) @(posedge clk);
      wr(`GPT_ADR_T2CTL, 32'h00);
      rd(`GPT_ADR_T2CNT);
      chk(q, 32'hFFF4, 32'hFFF8);
      rd(`GPT_ADR_IRQSTAT);
      chk(q & 32'h08, 32'h08, 32'h08);
      // Timer two as two 8-bit halves, both on the system clock
      wr(`GPT_ADR_CLKCTL, 32'h30);
      wr(`GPT_ADR_T2CNT, 32'h80FC);
      wr(`GPT_ADR_T2CTL, 32'h23);
      repeat (5) @(posedge clk);
      wr(`GPT_ADR_T2CTL, 32'h00);
      rd(`GPT_ADR_T2CNT);
      chk(q & 32'hFF, 32'hF3, 32'hF5);
      chk(q >> 8, 32'h87, 32'h89);
      // Slow and external oscillators over 8 as timer two/three clocks
      wr(`GPT_ADR_CLKCTL, 32'h00);
      wr(`GPT_ADR_T2CNT, 0);
      wr(`GPT_ADR_T2CTL, 32'h05);
      wr(`GPT_ADR_T3CTL, 32'h05);
      repeat (477) @(posedge clk);
      wr(`GPT_ADR_T2CTL, 32'h00);
      wr(`GPT_ADR_T3CTL, 32'h00);
      rd(`GPT_ADR_T2CNT);
      chk(q, ticks(3) - 1, ticks(3) + 1);
      rd(`GPT_ADR_T3CNT);
      chk(q, ticks(3) - 1, ticks(3) + 1);
      // Timer one in 8-bit auto-reload mode, then halted by split mode
      wr(`GPT_ADR_CLKCTL, 32'h08);
      wr(`GPT_ADR_T01MODE, 32'h20);
      wr(`GPT_ADR_T1CNT, 32'hF0FC);
      wr(`GPT_ADR_T01CTL, 32'h02);
      repeat (5) @(posedge clk);
      wr(`GPT_ADR_T01CTL, 32'h00);
      rd(`GPT_ADR_T1CNT);
      chk(q, 32'hF0F3, 32'hF0F5);
      v = q;
      rd(`GPT_ADR_IRQSTAT);
      chk(q & 32'h02, 32'h02, 32'h02);
      wr(`GPT_ADR_CLKCTL, 32'h04);
      wr(`GPT_ADR_T01MODE, 32'h33);
      wr(`GPT_ADR_T0CNT, 0);
      wr(`GPT_ADR_T01CTL, 32'h03);
      repeat (45) @(posedge clk);
      wr(`GPT_ADR_T01CTL, 32'h00);
      rd(`GPT_ADR_T0CNT);
      chk(q & 32'hFF, 47, 49);
      chk(q >> 8, 3, 5);
      rd(`GPT_ADR_T1CNT);
      chk(q, v, v);
      // Comparator rising edges latch timer three; the gap is the measured period
      wr(`GPT_ADR_T3CTL, 32'h19);
      cmp <= 1'b1;
      k = cycles;
      repeat (8) @(posedge clk);
      cmp <= 1'b0;
      rd(`GPT_ADR_T3CAP);
      v = q;
      repeat (3 + ($random(seed) & 31)) @(posedge clk);
      cmp <= 1'b1;
      c = cycles - k;
      repeat (8) @(posedge clk);
      rd(`GPT_ADR_T3CAP);
      chk((q - v) & 32'hFFFF, c, c);
      rd(`GPT_ADR_IRQSTAT);
      chk(q & 32'h80, 32'h80, 32'h80);
      test_done();
   end
endmodule
`default_nettype wire
